// ==== logic/lidc_decoder.sv ====
// Decoder end: routes local I/O cycles, checks widths, times out holes, decodes VMEbus slave windows.
//
// Notes on behaviour
// - Route 64KB battery RAM window, mirrored every 8KB.
// - Reserved holes never acknowledge; timer ends them.
// - Master uses byte accesses to serial controllers.
// - Narrow writes to local CSR block end in error.
// - Global CSR writes, all CSR reads, any width.
// - Master reads interrupt vector byte-wide.
// - Port command is two halfwords, upper first.
// - ECC windows answer only with mezzanine fitted.
// - VMEbus slave hit needs range and modifier match.
// - Global CSR block at programmable short I/O base.
`timescale 1ns/100ps
`default_nettype none
module lidc_decoder
   import lidc_pkg::*;
#(
   parameter int TW = lidc_pkg::TMR_W
) (
   input  wire logic                  mclk_in,
   input  wire logic                  sys_rst_in,
   lidc_if.dev                        lb,
   input  wire logic                  ecc_fitted_in,
   input  wire logic                  timer_en_in,
   input  wire logic [TW-1:0]         timer_period_in,
   output logic [lidc_pkg::LIDC_NT-1:0] tgt_sel_out,
   output logic [15:0]                tgt_ofs_out,
   output logic                       tgt_wr_out,
   output lidc_pkg::lidc_size_t       tgt_size_out,
   output logic [31:0]                tgt_wdata_out,
   input  wire logic [lidc_pkg::LIDC_NT-1:0] tgt_ack_in,
   input  wire logic [31:0]           tgt_rdata_in,
   input  wire logic                  vme_valid_in,
   input  wire logic [31:0]           vme_addr_in,
   input  wire logic [5:0]            vme_am_in,
   input  wire logic [31:0]           vme_start_in,
   input  wire logic [31:0]           vme_end_in,
   input  wire logic [5:0]            vme_am_cfg_in,
   output logic                       vme_hit_out,
   input  wire logic                  sio_valid_in,
   input  wire logic [15:0]           sio_addr_in,
   input  wire logic [15:0]           sio_base_in,
   output logic                       sio_hit_out
);
   import lidc_pkg::*;

   // ******************************************************
   // Parameter checks
   // ******************************************************
   if (TW < 2 || TW > 24) begin : g_bad_tw
      $error("lidc_decoder: timer width out of range");
   end

   // ******************************************************
   // State
   // ******************************************************
   typedef enum logic [1:0] {
      LIDC_ST_IDLE  = 2'b00,
      LIDC_ST_ROUTE = 2'b01,
      LIDC_ST_HOLE  = 2'b11
   } lidc_dstate_t;

   typedef struct packed {
      lidc_dstate_t         st;
      logic [2:0]           ecc_s;
      logic                 ecc_ok;
      logic [TW-1:0]        tmr;
      logic [LIDC_NT-1:0]   sel;
      logic [15:0]          ofs;
      logic                 wr;
      lidc_size_t           size;
      logic [31:0]          wdata;
      logic                 ack;
      logic                 berr;
      logic [31:0]          rdata;
      logic                 vme_hit;
      logic                 sio_hit;
   } lidc_dec_t;

   lidc_dec_t r_q;
   lidc_dec_t r_d;

   // ******************************************************
   // Next state
   // ******************************************************

   // One process holds all decisions so the answer, the selects and the
   // timer always move together in the same cycle.
   always_comb begin
      logic [2:0] tgt;
      logic       tmo;
      tgt = LIDC_T_HOLE;
      tmo = 1'b0;
      r_d = r_q;
      r_d.ack = 1'b0;
      r_d.berr = 1'b0;

      // Fitted strap: three stages, a change is taken once stages two and three agree.
      r_d.ecc_s = {r_q.ecc_s[1:0], ecc_fitted_in};
      if (r_q.ecc_s[1] == r_q.ecc_s[2]) begin
         r_d.ecc_ok = r_q.ecc_s[2];
      end

      // Slave window: inclusive bounds and an exact modifier match.
      r_d.vme_hit = vme_valid_in && vme_addr_in >= vme_start_in
                    && vme_addr_in <= vme_end_in && vme_am_in == vme_am_cfg_in;
      r_d.sio_hit = sio_valid_in
                    && sio_addr_in[15:SIO_BLK_LSB] == sio_base_in[15:SIO_BLK_LSB];

      // Timeout runs from the first cycle of any open access; a disabled
      // timer leaves an unanswered access open for good.
      if (r_q.st != LIDC_ST_IDLE && timer_en_in) begin
         if (r_q.tmr >= timer_period_in) begin
            tmo = 1'b1;
         end else begin
            r_d.tmr = r_q.tmr + 1'b1;
         end
      end

      case (r_q.st)
         LIDC_ST_IDLE: begin
            if (lb.lb_req) begin
               tgt = lidc_decode(lb.lb_addr);
               if (tgt == LIDC_T_ECC && !r_q.ecc_ok) begin
                  tgt = LIDC_T_HOLE;
               end
               r_d.tmr = '0;
               r_d.wr = lb.lb_wr;
               r_d.size = lb.lb_size;
               r_d.wdata = lb.lb_wdata;
               r_d.ofs = lb.lb_addr[15:0];
               if (tgt == LIDC_T_BATT) begin
                  r_d.ofs = lb.lb_addr[15:0] & BATT_MIRROR;
               end
               if (tgt == LIDC_T_LOC_CSR && lb.lb_wr && lb.lb_size != LIDC_SZ_WORD) begin
                  r_d.berr = 1'b1;
               end else if (tgt == LIDC_T_HOLE) begin
                  r_d.st = LIDC_ST_HOLE;
               end else begin
                  // Global block and reads of both blocks pass at any width.
                  r_d.sel = '0;
                  r_d.sel[tgt] = 1'b1;
                  r_d.st = LIDC_ST_ROUTE;
               end
            end
         end
         LIDC_ST_ROUTE: begin
            if (|(tgt_ack_in & r_q.sel)) begin
               r_d.ack = 1'b1;
               r_d.rdata = tgt_rdata_in;
               r_d.sel = '0;
               r_d.st = LIDC_ST_IDLE;
            end else if (tmo) begin
               r_d.berr = 1'b1;
               r_d.sel = '0;
               r_d.st = LIDC_ST_IDLE;
            end
         end
         LIDC_ST_HOLE: begin
            // No acknowledge ever comes from a hole; only the timer ends it.
            if (tmo) begin
               r_d.berr = 1'b1;
               r_d.st = LIDC_ST_IDLE;
            end
         end
         default: begin
            r_d.sel = '0;
            r_d.st = LIDC_ST_IDLE;
         end
      endcase
   end

   // ******************************************************
   // Registers
   // ******************************************************

   // Synchronous reset clears every field, so the state starts idle.
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   // ******************************************************
   // Outputs
   // ******************************************************

   // Every output is a field of the state register.
   assign lb.lb_ack                 = r_q.ack;
   assign lb.lb_bus_error_terminate = r_q.berr;
   assign lb.lb_rdata               = r_q.rdata;
   assign tgt_sel_out               = r_q.sel;
   assign tgt_ofs_out               = r_q.ofs;
   assign tgt_wr_out                = r_q.wr;
   assign tgt_size_out              = r_q.size;
   assign tgt_wdata_out             = r_q.wdata;
   assign vme_hit_out               = r_q.vme_hit;
   assign sio_hit_out               = r_q.sio_hit;

endmodule
`default_nettype wire

// ==== logic/lidc_pkg.sv ====
// Constants, types and the shared address decoder of the local I/O decode and check block.
package lidc_pkg;

   // ******************************************************
   // Access sizes and targets
   // ******************************************************
   typedef enum logic [1:0] {
      LIDC_SZ_BYTE = 2'h0,
      LIDC_SZ_HALF = 2'h1,
      LIDC_SZ_WORD = 2'h2
   } lidc_size_t;

   // Target indices; LIDC_T_HOLE means nobody answers.
   localparam int          LIDC_NT        = 7;
   localparam logic [2:0]  LIDC_T_LOC_CSR = 3'h0;
   localparam logic [2:0]  LIDC_T_GLB_CSR = 3'h1;
   localparam logic [2:0]  LIDC_T_ECC     = 3'h2;
   localparam logic [2:0]  LIDC_T_SERIAL  = 3'h3;
   localparam logic [2:0]  LIDC_T_LAN     = 3'h4;
   localparam logic [2:0]  LIDC_T_BATT    = 3'h5;
   localparam logic [2:0]  LIDC_T_EXT     = 3'h6;
   localparam logic [2:0]  LIDC_T_HOLE    = 3'h7;

   // ******************************************************
   // Address windows, inclusive bounds
   // ******************************************************
   localparam logic [31:0] LOC_CSR_LO  = 32'hfff40000;
   localparam logic [31:0] LOC_CSR_HI  = 32'hfff400ff;
   localparam logic [31:0] GLB_CSR_LO  = 32'hfff40100;
   localparam logic [31:0] GLB_CSR_HI  = 32'hfff401ff;
   localparam logic [31:0] ECC_LO      = 32'hfff43000;
   localparam logic [31:0] ECC_HI      = 32'hfff43fff;
   localparam logic [31:0] SERIAL_LO   = 32'hfff45000;
   localparam logic [31:0] SERIAL_HI   = 32'hfff45fff;
   localparam logic [31:0] LAN_LO      = 32'hfff46000;
   localparam logic [31:0] LAN_HI      = 32'hfff46fff;
   localparam logic [31:0] HOLE12_LO   = 32'hfffbd000;
   localparam logic [31:0] HOLE12_HI   = 32'hfffbffff;
   localparam logic [31:0] BATT_LO     = 32'hfffc0000;
   localparam logic [31:0] BATT_HI     = 32'hfffcffff;
   localparam logic [31:0] HOLE128_LO  = 32'hfffd0000;
   localparam logic [31:0] HOLE128_HI  = 32'hfffeffff;
   localparam logic [15:0] BATT_MIRROR = 16'h1fff;  // Contents repeat every 8KB.
   localparam logic [31:0] VEC_ADDR    = 32'hfff40068;  // Interrupt vector location.
   localparam int          SIO_BLK_LSB = 8;  // Global block spans 256 bytes of short I/O.
   localparam int          TMR_W       = 16;

   // Maps a local bus address onto a target index.
   function automatic logic [2:0] lidc_decode(input logic [31:0] a);
      logic [2:0] t;
      t = LIDC_T_EXT;
      if (a >= LOC_CSR_LO && a <= LOC_CSR_HI) t = LIDC_T_LOC_CSR;
      if (a >= GLB_CSR_LO && a <= GLB_CSR_HI) t = LIDC_T_GLB_CSR;
      if (a >= ECC_LO && a <= ECC_HI) t = LIDC_T_ECC;
      if (a >= SERIAL_LO && a <= SERIAL_HI) t = LIDC_T_SERIAL;
      if (a >= LAN_LO && a <= LAN_HI) t = LIDC_T_LAN;
      if (a >= BATT_LO && a <= BATT_HI) t = LIDC_T_BATT;
      if (a >= HOLE12_LO && a <= HOLE12_HI) t = LIDC_T_HOLE;
      if (a >= HOLE128_LO && a <= HOLE128_HI) t = LIDC_T_HOLE;
      return t;
   endfunction

endpackage

// ==== logic/lidc_if.sv ====
// Local bus interface joining the bus master end and the decoder end.
`timescale 1ns/100ps
`default_nettype none
interface lidc_if;
   import lidc_pkg::*;

   // ******************************************************
   // Cycle request and termination
   // ******************************************************
   logic             lb_req;
   logic [31:0]      lb_addr;
   logic             lb_wr;
   lidc_size_t       lb_size;
   logic [31:0]      lb_wdata;
   logic             lb_ack;
   logic             lb_bus_error_terminate;
   logic [31:0]      lb_rdata;

   modport mst (
      output lb_req, lb_addr, lb_wr, lb_size, lb_wdata,
      input  lb_ack, lb_bus_error_terminate, lb_rdata
   );

   modport dev (
      input  lb_req, lb_addr, lb_wr, lb_size, lb_wdata,
      output lb_ack, lb_bus_error_terminate, lb_rdata
   );
endinterface
`default_nettype wire

// ==== logic/lidc_master.sv ====
// Bus master end: issues local cycles and keeps the width rules of the local I/O devices.
`timescale 1ns/100ps
`default_nettype none
module lidc_master
   import lidc_pkg::*;
(
   input  wire logic            mclk_in,
   input  wire logic            sys_rst_in,
   lidc_if.mst                  lb,
   input  wire logic            cmd_valid_in,
   input  wire logic [31:0]     cmd_addr_in,
   input  wire logic            cmd_wr_in,
   input  wire lidc_pkg::lidc_size_t cmd_size_in,
   input  wire logic [31:0]     cmd_wdata_in,
   input  wire logic            cmd_port_in,
   output logic                 cmd_ready_out,
   output logic                 done_out,
   output logic                 err_out,
   output logic [31:0]          rdata_out
);
   import lidc_pkg::*;

   // ******************************************************
   // State
   // ******************************************************
   typedef enum logic {
      LIDC_MS_IDLE = 1'b0,
      LIDC_MS_WAIT = 1'b1
   } lidc_mstate_t;

   typedef struct packed {
      lidc_mstate_t st;
      logic         rdy;
      logic         req;
      logic [31:0]  addr;
      logic         wr;
      lidc_size_t   size;
      logic [31:0]  wdata;
      logic         second;
      logic [15:0]  low_half;
      logic         done;
      logic         err;
      logic [31:0]  rdata;
   } lidc_mst_t;

   lidc_mst_t r_q;
   lidc_mst_t r_d;

   // ******************************************************
   // Next state
   // ******************************************************

   // Width rules are checked before a cycle is issued, so a refused
   // command never reaches the bus.
   always_comb begin
      logic [2:0] tgt;
      tgt = lidc_decode(cmd_addr_in);
      r_d = r_q;
      r_d.req = 1'b0;
      r_d.done = 1'b0;
      r_d.err = 1'b0;
      case (r_q.st)
         LIDC_MS_IDLE: begin
            if (cmd_valid_in && r_q.rdy) begin
               r_d.addr = cmd_addr_in;
               r_d.wr = cmd_wr_in;
               r_d.size = cmd_size_in;
               r_d.wdata = cmd_wdata_in;
               r_d.second = 1'b0;
               if (tgt == LIDC_T_SERIAL && cmd_size_in != LIDC_SZ_BYTE) begin
                  r_d.done = 1'b1;
                  r_d.err = 1'b1;
               end else if (tgt == LIDC_T_LOC_CSR && cmd_wr_in && cmd_size_in != LIDC_SZ_WORD) begin
                  r_d.done = 1'b1;
                  r_d.err = 1'b1;
               end else begin
                  if (!cmd_wr_in && cmd_addr_in == VEC_ADDR) begin
                     r_d.size = LIDC_SZ_BYTE;
                  end
                  if (cmd_port_in && cmd_wr_in) begin
                     // Upper halfword goes first, lower one is kept for later.
                     r_d.size = LIDC_SZ_HALF;
                     r_d.wdata = {16'h0000, cmd_wdata_in[31:16]};
                     r_d.low_half = cmd_wdata_in[15:0];
                     r_d.second = 1'b1;
                  end
                  r_d.req = 1'b1;
                  r_d.st = LIDC_MS_WAIT;
               end
            end
         end
         LIDC_MS_WAIT: begin
            if (lb.lb_bus_error_terminate) begin
               // An error on the upper half drops the lower half as well.
               r_d.done = 1'b1;
               r_d.err = 1'b1;
               r_d.second = 1'b0;
               r_d.st = LIDC_MS_IDLE;
            end else if (lb.lb_ack && r_q.second) begin
               r_d.wdata = {16'h0000, r_q.low_half};
               r_d.second = 1'b0;
               r_d.req = 1'b1;
            end else if (lb.lb_ack) begin
               r_d.done = 1'b1;
               r_d.rdata = lb.lb_rdata;
               r_d.st = LIDC_MS_IDLE;
            end
         end
         default: begin
            r_d.st = LIDC_MS_IDLE;
         end
      endcase
      r_d.rdy = (r_d.st == LIDC_MS_IDLE);
   end

   // ******************************************************
   // Registers and outputs
   // ******************************************************

   // Synchronous reset; ready rises at the first edge after release.
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign lb.lb_req    = r_q.req;
   assign lb.lb_addr   = r_q.addr;
   assign lb.lb_wr     = r_q.wr;
   assign lb.lb_size   = r_q.size;
   assign lb.lb_wdata  = r_q.wdata;
   assign cmd_ready_out = r_q.rdy;
   assign done_out     = r_q.done;
   assign err_out      = r_q.err;
   assign rdata_out    = r_q.rdata;

endmodule
`default_nettype wire

// ==== verification/lidc_checker.sv ====
// Concurrent checks on the local bus joining the master end and the decoder end.
`timescale 1ns/100ps
`default_nettype none
module lidc_checker
   import lidc_pkg::*;
(
   input  wire logic                 mclk_in,
   input  wire logic                 sys_rst_in,
   input  wire logic                 lb_req,
   input  wire logic [31:0]          lb_addr,
   input  wire logic                 lb_wr,
   input  wire lidc_pkg::lidc_size_t lb_size,
   input  wire logic                 lb_ack,
   input  wire logic                 lb_bus_error_terminate
);
   import lidc_pkg::*;

   // ******************************************************
   // Address classes
   // ******************************************************
   default clocking @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   logic hole;
   logic lan_wr;
   logic lan_2nd_q;
   logic lan_2nd_d;

   // Window tests; the hole timing below assumes a timer period of four.
   assign hole   = (lb_addr >= HOLE12_LO && lb_addr <= HOLE12_HI) || (lb_addr >= HOLE128_LO && lb_addr <= HOLE128_HI);
   assign lan_wr = lb_req && lb_wr && lb_size == LIDC_SZ_HALF && lb_addr >= LAN_LO && lb_addr <= LAN_HI;
   assign lan_2nd_d = lb_bus_error_terminate ? 1'b0 : (lan_wr ? !lan_2nd_q : lan_2nd_q);

   // Remembers that a port command half is owed; an error drops the owed half.
   always_ff @(posedge mclk_in) begin
      lan_2nd_q <= sys_rst_in ? 1'b0 : lan_2nd_d;
   end

   // ******************************************************
   // Assertions
   // ******************************************************
   hole_timeout_a: assert property (lb_req && hole |-> ##1 (!lb_ack && !lb_bus_error_terminate)[*5] ##1 lb_bus_error_terminate)
      else $error("hole cycle not ended by timeout");
   answer_excl_a: assert property (!(lb_ack && lb_bus_error_terminate))
      else $error("ack and error together");
   serial_byte_a: assert property (lb_req && lb_addr >= SERIAL_LO && lb_addr <= SERIAL_HI |-> lb_size == LIDC_SZ_BYTE)
      else $error("wide serial access on bus");
   local_control_status_block_word_a: assert property (lb_req && lb_wr && lb_addr >= LOC_CSR_LO && lb_addr <= LOC_CSR_HI |-> lb_size == LIDC_SZ_WORD)
      else $error("narrow local block write on bus");
   glb_write_a: assert property (lb_req && lb_addr >= GLB_CSR_LO && lb_addr <= GLB_CSR_HI |=> !lb_bus_error_terminate)
      else $error("global block access refused");
   vec_byte_a: assert property (lb_req && !lb_wr && lb_addr == VEC_ADDR |-> lb_size == LIDC_SZ_BYTE)
      else $error("vector read not byte wide");
   lan_pair_a: assert property (lan_wr && !lan_2nd_q |-> ##[2:40] (lb_bus_error_terminate || lan_wr))
      else $error("second command half missing");
   berr_pulse_a: assert property ($rose(lb_bus_error_terminate) |=> !lb_bus_error_terminate)
      else $error("error termination too long");

   // Main scenarios seen.
   cover property (lb_req && hole);
   cover property (lan_wr && lan_2nd_q);
   cover property (lb_req && lb_addr >= SERIAL_LO && lb_addr <= SERIAL_HI);
endmodule
`default_nettype wire

// ==== verification/tb_local_io_decode_check.sv ====
// Self-checking bench: master and decoder ends joined, plus a rule-breaking driver on a second bus.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_local_io_decode_check;
   import lidc_pkg::*;

   // ******************************************************
   // Signals
   // ******************************************************
   localparam int P = 4;
   logic        mclk_in = 0, sys_rst_in = 1, ecc = 0, cmd_valid = 0, cmd_wr = 0, cmd_port = 0;
   logic        m_ready, m_done, m_err, vme_valid = 0, vme_hit, sio_valid = 0, sio_hit;
   logic [31:0] cmd_addr = 0, cmd_wdata = 0, m_rdata, tgt_rdata = 0, vme_addr = 0, vme_start = 0, vme_end = 0, r;
   logic [31:0] seed = 32'hf12c;  // Starting state 61740.
   logic [15:0] ofs, ofs_seen = 0, sio_addr = 0, sio_base = 0;
   logic [5:0]  vme_am = 0, vme_am_cfg = 0;
   logic [6:0]  sel, sel_b, sel_seen = 0, tgt_ack = 0, mute = 0;
   lidc_size_t  cmd_size = LIDC_SZ_BYTE, last_size;
   logic [31:0] wq[$];
   int          failures = 0, n_tests = 0, nreq = 0;

   lidc_if lb0 ();
   lidc_if lb1 ();
   lidc_master lidc_master_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .lb(lb0), .cmd_valid_in(cmd_valid),
      .cmd_addr_in(cmd_addr), .cmd_wr_in(cmd_wr), .cmd_size_in(cmd_size), .cmd_wdata_in(cmd_wdata),
      .cmd_port_in(cmd_port), .cmd_ready_out(m_ready), .done_out(m_done), .err_out(m_err), .rdata_out(m_rdata));
   lidc_decoder lidc_decoder_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .lb(lb0), .ecc_fitted_in(ecc),
      .timer_en_in(1'b1), .timer_period_in(16'(P)), .tgt_sel_out(sel), .tgt_ofs_out(ofs), .tgt_wr_out(),
      .tgt_size_out(), .tgt_wdata_out(), .tgt_ack_in(tgt_ack), .tgt_rdata_in(tgt_rdata), .vme_valid_in(vme_valid),
      .vme_addr_in(vme_addr), .vme_am_in(vme_am), .vme_start_in(vme_start), .vme_end_in(vme_end),
      .vme_am_cfg_in(vme_am_cfg), .vme_hit_out(vme_hit), .sio_valid_in(sio_valid), .sio_addr_in(sio_addr),
      .sio_base_in(sio_base), .sio_hit_out(sio_hit));
   // Second decoder faces the bench directly; its targets answer as soon as selected.
   lidc_decoder lidc_decoder_inst_b (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .lb(lb1), .ecc_fitted_in(ecc),
      .timer_en_in(1'b1), .timer_period_in(16'(P)), .tgt_sel_out(sel_b), .tgt_ofs_out(), .tgt_wr_out(),
      .tgt_size_out(), .tgt_wdata_out(), .tgt_ack_in(sel_b), .tgt_rdata_in(tgt_rdata), .vme_valid_in(vme_valid),
      .vme_addr_in(vme_addr), .vme_am_in(vme_am), .vme_start_in(vme_start), .vme_end_in(vme_end),
      .vme_am_cfg_in(vme_am_cfg), .vme_hit_out(), .sio_valid_in(sio_valid), .sio_addr_in(sio_addr),
      .sio_base_in(sio_base), .sio_hit_out());
   lidc_checker lidc_checker_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .lb_req(lb0.lb_req),
      .lb_addr(lb0.lb_addr), .lb_wr(lb0.lb_wr), .lb_size(lb0.lb_size), .lb_ack(lb0.lb_ack),
      .lb_bus_error_terminate(lb0.lb_bus_error_terminate));

   // ******************************************************
   // Clock, bus watch and targets
   // ******************************************************
   always #2.5 mclk_in = ~mclk_in;

   // Logs every request on the joined bus so refusals and command halves can be counted.
   always @(posedge mclk_in) begin
      if (lb0.lb_req === 1'b1) begin
         nreq++;
         last_size = lb0.lb_size;
         wq.push_back(lb0.lb_wdata);
      end
   end

   // Targets answer at random but by the second look at the latest, so a short timer never beats a live target.
   always @(negedge mclk_in) begin
      tgt_ack <= '0;
      if (|sel) begin
         ofs_seen = ofs;
         if (xs() % 3 == 0 || sel_seen == sel) tgt_ack <= sel & ~mute;
         sel_seen = sel;
      end
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic lidc_size_t sz(input logic [1:0] b);
      return (b == 2'h3) ? LIDC_SZ_WORD : lidc_size_t'(b);
   endfunction

   // ******************************************************
   // Tasks
   // ******************************************************
   // One master command, waited for under a bounded count, with its outcome compared.
   task automatic op(input logic [31:0] a, input logic w, input lidc_size_t s, input logic pt, input logic xe);
      int k;
      tgt_rdata = xs();
      @(negedge mclk_in);
      {cmd_addr, cmd_wr, cmd_port, cmd_wdata, cmd_valid} = {a, w, pt, xs(), 1'b1};
      cmd_size = s;
      for (k = 0; k < 60 && m_ready !== 1'b1; k++) @(negedge mclk_in);
      @(negedge mclk_in);
      cmd_valid = 0;
      for (k = 0; k < 60 && m_done !== 1'b1; k++) @(negedge mclk_in);
      if (k == 60) failures++;
      `CHK("err", xe, m_err)
      if (!w && !xe) `CHK("rdata", tgt_rdata, m_rdata)
   endtask

   // Raw write to the local block on the second bus; the error pulse stands one cycle after the take edge.
   task automatic bcyc(input lidc_size_t s, input logic xb);
      @(negedge mclk_in);
      {lb1.lb_req, lb1.lb_addr, lb1.lb_wr} = {1'b1, LOC_CSR_LO + 32'h8, 1'b1};
      lb1.lb_size = s;
      @(negedge mclk_in);
      `CHK("berr_b", xb, lb1.lb_bus_error_terminate)
      lb1.lb_req = 0;
      @(negedge mclk_in);
      repeat (4) @(negedge mclk_in);
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // Cuts a hang short well beyond the expected run length.
   initial begin
      #200us;
      failures++;
      close_out();
   end

   // ******************************************************
   // Main sequence
   // ******************************************************
   initial begin
      int n0;
      {lb1.lb_req, lb1.lb_addr, lb1.lb_wr, lb1.lb_wdata} = '0;
      lb1.lb_size = LIDC_SZ_BYTE;
      repeat (3) @(negedge mclk_in);
      sys_rst_in = 0;
      // Random traffic over the battery, CSR, serial and external classes, with holes mixed in.
      for (int i = 0; i < 60; i++) begin
         r = xs();
         case (r[2:0])
            0: begin
               op(BATT_LO + {16'h0, r[31:16]}, r[3], sz(r[5:4]), 0, 0);
               `CHK("mirror", {3'h0, r[28:16]}, ofs_seen)
               `CHK("batt_sel", 7'h20, sel_seen)
            end
            1: op(GLB_CSR_LO + r[15:8], r[3], sz(r[5:4]), 0, 0);
            2: op(LOC_CSR_LO + r[15:8], 0, sz(r[5:4]), 0, 0);
            3: op(LOC_CSR_LO + r[15:8], 1, LIDC_SZ_WORD, 0, 0);
            4: op(SERIAL_LO + r[15:4], r[3], LIDC_SZ_BYTE, 0, 0);
            5: op({4'h1, r[31:4]}, r[3], sz(r[5:4]), 0, 0);
            6: begin
               op(VEC_ADDR, 0, sz(r[5:4]), 0, 0);
               `CHK("vec_size", LIDC_SZ_BYTE, last_size)
            end
            default: op(r[3] ? HOLE12_LO + r[15:4] : HOLE128_LO + {15'h0, r[31:15]}, r[4], sz(r[6:5]), 0, 1);
         endcase
      end
      // Refused widths never reach the bus.
      for (int s = 1; s < 3; s++) begin
         n0 = nreq;
         op(SERIAL_LO + 32'h800, 1, lidc_size_t'(s), 0, 1);
         op(LOC_CSR_LO, 1, lidc_size_t'(s - 1), 0, 1);
         `CHK("no_bus", n0, nreq)
         bcyc(lidc_size_t'(s - 1), 1);
      end
      bcyc(LIDC_SZ_WORD, 0);
      // Error-correcting windows answer only once the mezzanine is seen.
      op(ECC_LO, 0, LIDC_SZ_BYTE, 0, 1);
      ecc = 1;
      repeat (5) @(negedge mclk_in);
      op(ECC_HI, 0, LIDC_SZ_BYTE, 0, 0);
      `CHK("ecc_sel", 7'h04, sel_seen)
      // A target that never answers is ended by the timer.
      mute = 7'h40;
      op(32'h2000_0000, 0, LIDC_SZ_WORD, 0, 1);
      // Port command halves, upper first; an error on the first drops the second.
      mute = 7'h00;
      wq.delete();
      op(LAN_LO, 1, LIDC_SZ_WORD, 1, 0);
      `CHK("halves", 2, wq.size())
      `CHK("upper", {16'h0, cmd_wdata[31:16]}, wq[0])
      `CHK("lower", {16'h0, cmd_wdata[15:0]}, wq[1])
      mute = 7'h10;
      wq.delete();
      op(LAN_LO + 32'h10, 1, LIDC_SZ_WORD, 1, 1);
      `CHK("dropped", 1, wq.size())
      // Slave and short I/O decoders, including range edges.
      for (int i = 0; i < 40; i++) begin
         r = xs();
         vme_start = {r[31:8], 8'h00};
         vme_end = vme_start + 32'h100;
         case (r[2:0])
            0: vme_addr = vme_start - 1;
            1: vme_addr = vme_start;
            2: vme_addr = vme_end;
            3: vme_addr = vme_end + 1;
            default: vme_addr = vme_start + r[7:0];
         endcase
         {vme_am, vme_am_cfg, vme_valid, sio_valid} = {r[13:8], r[14] ? r[13:8] : r[20:15], r[21] | r[22], r[23] | r[24]};
         sio_base = r[15:0] ^ r[31:16];
         sio_addr = r[25] ? {sio_base[15:8], r[7:0]} : r[31:16];
         @(negedge mclk_in);
         `CHK("vme_hit", vme_valid && vme_addr >= vme_start && vme_addr <= vme_end && vme_am == vme_am_cfg, vme_hit)
         `CHK("sio_hit", sio_valid && sio_addr[15:8] == sio_base[15:8], sio_hit)
      end
      close_out();
   end
endmodule
`default_nettype wire
